// file: hdl/risc_core_alu_datapath.sv
// Two-stage fetch/execute core with 8-bit ALU and working register.
// Assumes sys_clk is the oscillator input; master clear and mode pins
// are asynchronous; program words are loaded through the load port.
// Function
// - Each instruction is one 14-bit word, never two.
// - A whole instruction word is fetched per cycle on its own bus.
// - Fetch overlaps execution; instructions take one cycle unless they branch or take a skip.
// - Program memory is internal, 512, 1K or 2K words deep.
// - Special registers, program counter too, live in the file map.
// - Any operation works on any register under any addressing.
// - The ALU is 8 bits and adds, subtracts, shifts and does logic.
// - Arithmetic is two's complement.
// - Two-operand ops use W plus a file register or literal.
// - Single-operand ops use W or a file register.
// - The 8-bit working register has no file address.
// - The ALU updates carry, nibble carry and zero per instruction.
// - On subtraction carry and nibble carry report borrows.
// - In RC mode the rate output runs at a quarter of the clock.
// - Master clear is active low and holds the core in reset.
// - The clock divides into four phases forming one cycle.
// - Operand is read in phase three, destination written in four.
// - A branch discards the fetched word, taking two cycles.
`timescale 1ns/1ns
`default_nettype none

module risc_core_alu_datapath
   import risc_core_pkg::*;
#(
   parameter int PROG_WORDS = PROG_DEPTH,
   parameter int DATA_WORDS = DATA_DEPTH
) (
   // Clock and reset
   input wire logic sys_clk,
   input wire logic resetn,
   // Device pins
   input wire logic master_clear_n,
   input wire logic rc_mode,
   output logic instr_rate_out,
   // Program memory load port
   input wire logic load_en,
   input wire logic [PC_WIDTH-1:0] load_addr,
   input wire logic [INSTR_WIDTH-1:0] load_word,
   // Core state
   output logic [DATA_WIDTH-1:0] work_reg,
   output logic [DATA_WIDTH-1:0] status_reg,
   output logic [PC_WIDTH-1:0] prog_counter
);

   localparam int PA_W = $clog2(PROG_WORDS);
   localparam int DA_W = $clog2(DATA_WORDS);
   localparam int SP_W = $clog2(STACK_DEPTH);

   logic master_clear_n_meta, master_clear_n_sync, rc_meta, rc_sync, core_rst;
   phase_type phase, next_phase;
   logic [INSTR_WIDTH-1:0] ir, next_ir, fetched, next_fetched;
   logic [INSTR_WIDTH-1:0] prog_rdata;
   logic [PC_WIDTH-1:0] next_pc, fetch_addr, next_fetch_addr;
   logic [PC_WIDTH-1:0] stack [STACK_DEPTH];
   logic [PC_WIDTH-1:0] next_stack [STACK_DEPTH];
   logic [SP_W-1:0] sp, next_sp;
   logic flush, next_flush, next_rate;
   logic [7:0] operand, next_operand, next_work, next_status;
   logic [7:0] fsr, next_fsr;
   logic [PC_WIDTH-9:0] pclath, next_pclath;
   logic [7:0] dmem_rdata, file_addr, file_data, alu_b, result;
   logic [9:0] alu_out;
   logic [2:0] flag_sel;
   alu_op_type op;
   logic use_lit, dest_w, wr_en, is_call, is_jump, is_ret;
   logic bit_test, zero_skip, core_file, file_wr, dmem_we;
   logic pcl_wr, skip, branch;

   // -------------------------------------------------------------
   // Pin synchronisers and reset
   // -------------------------------------------------------------
   // Two flops on each pin before any logic reads it
   always_ff @(posedge sys_clk) begin
      if (!resetn) begin
         master_clear_n_meta <= 1'b0;
         master_clear_n_sync <= 1'b0;
         rc_meta <= 1'b0;
         rc_sync <= 1'b0;
      end else begin
         master_clear_n_meta <= master_clear_n;
         master_clear_n_sync <= master_clear_n_meta;
         rc_meta <= rc_mode;
         rc_sync <= rc_meta;
      end
   end

   // Core held in reset while master clear is low
   assign core_rst = !resetn || !master_clear_n_sync;

   // -------------------------------------------------------------
   // Memories
   // -------------------------------------------------------------
   // Program store wraps above its depth
   sync_mem #(
      .WIDTH(INSTR_WIDTH),
      .DEPTH(PROG_WORDS)
   ) prog_mem (
      .sys_clk(sys_clk),
      .wr_en(load_en),
      .wr_addr(load_addr[PA_W-1:0]),
      .wr_data(load_word),
      .rd_addr(fetch_addr[PA_W-1:0]),
      .rd_data(prog_rdata)
   );

   // File memory, clocked read lands in phase three
   sync_mem #(
      .WIDTH(DATA_WIDTH),
      .DEPTH(DATA_WORDS)
   ) data_mem (
      .sys_clk(sys_clk),
      .wr_en(dmem_we),
      .wr_addr(file_addr[DA_W-1:0]),
      .wr_data(result),
      .rd_addr(file_addr[DA_W-1:0]),
      .rd_data(dmem_rdata)
   );

   // -------------------------------------------------------------
   // Instruction decode
   // -------------------------------------------------------------
   // Orthogonal decode: every file operation takes any address
   always_comb begin
      op = ALU_PASS;
      use_lit = 1'b0;
      dest_w = 1'b0;
      wr_en = 1'b0;
      is_call = 1'b0;
      is_jump = 1'b0;
      is_ret = 1'b0;
      bit_test = 1'b0;
      zero_skip = 1'b0;
      case (ir[13:12])
         GRP_BYTE: begin
            op = byte_op(ir[11:8]);
            wr_en = 1'b1;
            dest_w = !ir[7];
            zero_skip = ir[11:8] == OP_DEC_SKIP ||
               ir[11:8] == OP_INC_SKIP;
            if (ir[11:8] == OP_SYSTEM) begin
               dest_w = 1'b0;
               wr_en = ir[7];
               is_ret = ir == RETURN_WORD || ir == RETFIE_WORD;
            end
         end
         GRP_BIT: begin
            op = ir[10] ? ALU_BSET : ALU_BCLR;
            wr_en = !ir[11];
            bit_test = ir[11];
         end
         GRP_JUMP: begin
            is_jump = 1'b1;
            is_call = !ir[11];
         end
         default: begin
            op = lit_op(ir[11:8]);
            use_lit = 1'b1;
            dest_w = 1'b1;
            wr_en = 1'b1;
            is_ret = ir[11:10] == LIT_RETURN;
         end
      endcase
   end

   // -------------------------------------------------------------
   // Operand fetch and ALU
   // -------------------------------------------------------------
   // Address 0 goes indirect through the select register
   always_comb begin
      if (ir[6:0] == ADDR_INDIRECT) begin
         file_addr = fsr;
      end else begin
         file_addr = {status_reg[ST_BANK], ir[6:0]};
      end
      core_file = is_core_file(file_addr);
      // Core registers answer in the file map; W has no address
      if (file_addr[6:0] == ADDR_PC_LOW) begin
         file_data = fetch_addr[7:0];
      end else if (file_addr[6:0] == ADDR_STATUS) begin
         file_data = status_reg;
      end else if (file_addr[6:0] == ADDR_SELECT) begin
         file_data = fsr;
      end else if (file_addr[6:0] == ADDR_PC_LATCH) begin
         file_data = {3'h0, pclath};
      end else if (file_addr[6:0] == ADDR_INDIRECT) begin
         file_data = 8'h00;
      end else begin
         file_data = dmem_rdata;
      end
   end

   // Second operand is the file value or the literal
   assign alu_b = use_lit ? ir[7:0] : operand;
   assign alu_out = alu_calc(op, work_reg, alu_b, ir[9:7],
      status_reg[ST_CARRY]);
   assign result = alu_out[7:0];

   // Moves of literals, skips and bit ops leave the flags alone
   assign flag_sel = (zero_skip || bit_test || (use_lit && !ir[11])) ?
      3'h0 : flag_mask(op);
   assign file_wr = wr_en && !dest_w;
   assign dmem_we = phase == PHASE_FOUR && file_wr && !core_file;
   assign pcl_wr = file_wr && file_addr[6:0] == ADDR_PC_LOW;
   assign skip = bit_test ? (operand[ir[9:7]] == ir[10]) :
      (zero_skip && result == 8'h00);
   assign branch = is_jump || is_ret || pcl_wr;

   // -------------------------------------------------------------
   // Pipeline and execute
   // -------------------------------------------------------------
   // Phase sequencer, fetch, operand capture and write-back
   always_comb begin
      next_phase = PHASE_ONE;
      next_ir = ir;
      next_fetched = fetched;
      next_pc = prog_counter;
      next_fetch_addr = fetch_addr;
      next_flush = flush;
      next_operand = operand;
      next_work = work_reg;
      next_status = status_reg;
      next_fsr = fsr;
      next_pclath = pclath;
      next_stack = stack;
      next_sp = sp;
      case (phase)
         PHASE_ONE: begin
            next_phase = PHASE_TWO;
            next_ir = flush ? NOP_WORD : fetched;
            next_fetch_addr = prog_counter;
            next_pc = prog_counter + 1'b1;
            next_flush = 1'b0;
         end
         PHASE_TWO: begin
            next_phase = PHASE_THREE;
         end
         PHASE_THREE: begin
            next_phase = PHASE_FOUR;
            next_operand = file_data;
         end
         default: begin
            next_phase = PHASE_ONE;
            next_fetched = prog_rdata;
            if (wr_en && dest_w) begin
               next_work = result;
            end
            if (file_wr && file_addr[6:0] == ADDR_STATUS) begin
               next_status = (status_reg & ~STATUS_WR_MASK) |
                  (result & STATUS_WR_MASK);
            end else if (file_wr && file_addr[6:0] == ADDR_SELECT) begin
               next_fsr = result;
            end else if (file_wr && file_addr[6:0] == ADDR_PC_LATCH) begin
               next_pclath = result[PC_WIDTH-9:0];
            end
            // Flag update overrides a direct write of status
            if (flag_sel[0]) begin
               next_status[ST_CARRY] = alu_out[9];
            end
            if (flag_sel[1]) begin
               next_status[ST_NIBBLE] = alu_out[8];
            end
            if (flag_sel[2]) begin
               next_status[ST_ZERO] = result == 8'h00;
            end
            if (is_call) begin
               next_stack[sp] = fetch_addr;
               next_sp = sp + 1'b1;
            end
            if (is_ret) begin
               next_sp = sp - 1'b1;
               next_pc = stack[sp - 1'b1];
            end
            if (is_jump) begin
               next_pc = {pclath[4:3], ir[10:0]};
            end
            if (pcl_wr) begin
               next_pc = {pclath, result};
            end
            // Drop the word fetched behind a branch or skip
            if (branch || skip) begin
               next_flush = 1'b1;
            end
         end
      endcase
      next_rate = rc_sync &&
         (next_phase == PHASE_THREE || next_phase == PHASE_FOUR);
   end

   // Register the pipeline and execute state
   always_ff @(posedge sys_clk) begin
      if (core_rst) begin
         phase <= PHASE_ONE;
         ir <= NOP_WORD;
         fetched <= NOP_WORD;
         prog_counter <= '0;
         fetch_addr <= '0;
         flush <= 1'b0;
         operand <= 8'h00;
         work_reg <= 8'h00;
         status_reg <= STATUS_RESET;
         fsr <= 8'h00;
         pclath <= '0;
         sp <= '0;
         instr_rate_out <= 1'b0;
      end else begin
         phase <= next_phase;
         ir <= next_ir;
         fetched <= next_fetched;
         prog_counter <= next_pc;
         fetch_addr <= next_fetch_addr;
         flush <= next_flush;
         operand <= next_operand;
         work_reg <= next_work;
         status_reg <= next_status;
         fsr <= next_fsr;
         pclath <= next_pclath;
         sp <= next_sp;
         instr_rate_out <= next_rate;
      end
   end

   // Return stack holds data only, no reset needed
   always_ff @(posedge sys_clk) begin
      stack <= next_stack;
   end

   // -------------------------------------------------------------
   // Checks
   // -------------------------------------------------------------
   default clocking chk_clk @(posedge sys_clk); endclocking
   default disable iff (core_rst);

   a_phase_wraps: assert property (
      phase == PHASE_FOUR |=> phase == PHASE_ONE ##3 phase == PHASE_FOUR)
      else $error("phase sequence broken");

   a_ir_once_per_cycle: assert property (
      $changed(ir) |-> $past(phase) == PHASE_ONE)
      else $error("instruction latched outside phase one");

   a_branch_flush: assert property (
      (phase == PHASE_FOUR && branch) |=> flush ##1
      (ir == NOP_WORD && !flush))
      else $error("branch did not discard fetched word");

   a_w_phase_four: assert property (
      phase != PHASE_FOUR |=> $stable(work_reg))
      else $error("working register written outside phase four");

   a_sub_borrow: assert property (
      (phase == PHASE_FOUR && op == ALU_SUB && flag_sel[0]) |=>
      status_reg[ST_CARRY] == ($past(alu_b) >= $past(work_reg)))
      else $error("subtract carry is not the no-borrow bit");

   a_sub_nibble: assert property (
      (phase == PHASE_FOUR && op == ALU_SUB && flag_sel[1]) |=>
      status_reg[ST_NIBBLE] ==
      ($past(alu_b[3:0]) >= $past(work_reg[3:0])))
      else $error("subtract nibble flag is not the no-borrow bit");

   a_add_carry: assert property (
      (phase == PHASE_FOUR && op == ALU_ADD && flag_sel[0]) |=>
      status_reg[ST_CARRY] ==
      (({1'b0, $past(alu_b)} + {1'b0, $past(work_reg)}) > 9'h0FF))
      else $error("add carry wrong");

   a_zero_flag: assert property (
      (phase == PHASE_FOUR && flag_sel[2]) |=>
      status_reg[ST_ZERO] == ($past(result) == 8'h00))
      else $error("zero flag does not match result");

   a_rate_quarter: assert property (
      ($rose(instr_rate_out) && rc_sync) |-> instr_rate_out ##1
      instr_rate_out ##1 (!instr_rate_out || !rc_sync))
      else $error("rate output not half of four phases");

endmodule

`default_nettype wire

// file: hdl/risc_core_pkg.sv
// Shared constants, types and ALU functions for the core datapath.
// Assumes an 8-bit data path and 14-bit instruction words.
`default_nettype none

package risc_core_pkg;

   // ------------------------------------------------------------
   // Widths, depths and timing
   // ------------------------------------------------------------
   localparam int INSTR_WIDTH = 14;
   localparam int DATA_WIDTH = 8;
   localparam int PC_WIDTH = 13;
   localparam int PROG_DEPTH = 2048;
   localparam int DATA_DEPTH = 256;
   localparam int STACK_DEPTH = 8;
   localparam int OSC_DIVIDE = 4;
   localparam int CLK_PERIOD_NS = 100;
   localparam int INSTR_CYCLE_NS = CLK_PERIOD_NS * OSC_DIVIDE;

   // ------------------------------------------------------------
   // File addresses held inside the core
   // ------------------------------------------------------------
   localparam logic [6:0] ADDR_INDIRECT = 7'h00;
   localparam logic [6:0] ADDR_PC_LOW = 7'h02;
   localparam logic [6:0] ADDR_STATUS = 7'h03;
   localparam logic [6:0] ADDR_SELECT = 7'h04;
   localparam logic [6:0] ADDR_PC_LATCH = 7'h0A;

   // ------------------------------------------------------------
   // Status fields, reset values and instruction codes
   // ------------------------------------------------------------
   localparam int ST_CARRY = 0;
   localparam int ST_NIBBLE = 1;
   localparam int ST_ZERO = 2;
   localparam int ST_BANK = 5;
   localparam logic [7:0] STATUS_RESET = 8'h18;
   localparam logic [7:0] STATUS_WR_MASK = 8'hE7;
   localparam logic [13:0] NOP_WORD = 14'h0000;
   localparam logic [13:0] RETURN_WORD = 14'h0008;
   localparam logic [13:0] RETFIE_WORD = 14'h0009;
   localparam logic [1:0] GRP_BYTE = 2'h0;
   localparam logic [1:0] GRP_BIT = 2'h1;
   localparam logic [1:0] GRP_JUMP = 2'h2;
   localparam logic [3:0] OP_SYSTEM = 4'h0;
   localparam logic [3:0] OP_DEC_SKIP = 4'hB;
   localparam logic [3:0] OP_INC_SKIP = 4'hF;
   localparam logic [1:0] LIT_RETURN = 2'h1;

   typedef enum logic [1:0] {
      PHASE_ONE, PHASE_TWO, PHASE_THREE, PHASE_FOUR
   } phase_type;

   typedef enum logic [3:0] {
      ALU_PASS, ALU_PASS_W, ALU_ADD, ALU_SUB, ALU_AND, ALU_IOR, ALU_XOR,
      ALU_COM, ALU_INC, ALU_DEC, ALU_RRF, ALU_RLF, ALU_SWAP, ALU_CLR,
      ALU_BCLR, ALU_BSET
   } alu_op_type;

   // Byte-oriented opcode to ALU operation
   function automatic alu_op_type byte_op(input logic [3:0] code);
      case (code)
         4'h0: return ALU_PASS_W;
         4'h1: return ALU_CLR;
         4'h2: return ALU_SUB;
         4'h3: return ALU_DEC;
         4'h4: return ALU_IOR;
         4'h5: return ALU_AND;
         4'h6: return ALU_XOR;
         4'h7: return ALU_ADD;
         4'h8: return ALU_PASS;
         4'h9: return ALU_COM;
         4'hA: return ALU_INC;
         4'hB: return ALU_DEC;
         4'hC: return ALU_RRF;
         4'hD: return ALU_RLF;
         4'hE: return ALU_SWAP;
         default: return ALU_INC;
      endcase
   endfunction

   // Literal opcode to ALU operation
   function automatic alu_op_type lit_op(input logic [3:0] code);
      if (!code[3]) return ALU_PASS;
      else if (code[2]) return code[1] ? ALU_ADD : ALU_SUB;
      else if (code[1:0] == 2'h0) return ALU_IOR;
      else if (code[1:0] == 2'h1) return ALU_AND;
      else if (code[1:0] == 2'h2) return ALU_XOR;
      else return ALU_PASS;
   endfunction

   // Flags an operation may touch: {zero, nibble carry, carry}
   function automatic logic [2:0] flag_mask(input alu_op_type op);
      case (op)
         ALU_ADD, ALU_SUB: return 3'h7;
         ALU_RRF, ALU_RLF: return 3'h1;
         ALU_AND, ALU_IOR, ALU_XOR, ALU_COM, ALU_INC, ALU_DEC, ALU_CLR,
         ALU_PASS: return 3'h4;
         default: return 3'h0;
      endcase
   endfunction

   // True for file addresses answered by core registers
   function automatic logic is_core_file(input logic [7:0] addr);
      return addr[6:0] == ADDR_INDIRECT || addr[6:0] == ADDR_PC_LOW ||
         addr[6:0] == ADDR_STATUS || addr[6:0] == ADDR_SELECT ||
         addr[6:0] == ADDR_PC_LATCH;
   endfunction

   // 8-bit ALU, returns {carry, nibble carry, result}
   function automatic logic [9:0] alu_calc(input alu_op_type op,
      input logic [7:0] a, input logic [7:0] b, input logic [2:0] sel,
      input logic cin);
      logic [8:0] sum;
      logic [4:0] low;
      logic [7:0] res;
      logic c;
      sum = 9'h000;
      low = 5'h00;
      res = b;
      c = cin;
      case (op)
         ALU_ADD: begin
            sum = {1'b0, b} + {1'b0, a};
            low = {1'b0, b[3:0]} + {1'b0, a[3:0]};
            res = sum[7:0];
            c = sum[8];
         end
         ALU_SUB: begin
            // Two's complement: b + ~a + 1, carry high means no borrow
            sum = {1'b0, b} + {1'b0, ~a} + 9'h001;
            low = {1'b0, b[3:0]} + {1'b0, ~a[3:0]} + 5'h01;
            res = sum[7:0];
            c = sum[8];
         end
         ALU_AND: res = a & b;
         ALU_IOR: res = a | b;
         ALU_XOR: res = a ^ b;
         ALU_COM: res = ~b;
         ALU_INC: res = b + 8'h01;
         ALU_DEC: res = b - 8'h01;
         ALU_RRF: begin
            res = {cin, b[7:1]};
            c = b[0];
         end
         ALU_RLF: begin
            res = {b[6:0], cin};
            c = b[7];
         end
         ALU_SWAP: res = {b[3:0], b[7:4]};
         ALU_CLR: res = 8'h00;
         ALU_BCLR: res = b & ~(8'h01 << sel);
         ALU_BSET: res = b | (8'h01 << sel);
         ALU_PASS_W: res = a;
         default: res = b;
      endcase
      return {c, low[4], res};
   endfunction

endpackage

`default_nettype wire

// file: hdl/sync_mem.sv
// Single-port-write, registered-read memory for program and data.
// Assumes one clock; contents are not reset.
`timescale 1ns/1ns
`default_nettype none

module sync_mem #(
   parameter int WIDTH = 8,
   parameter int DEPTH = 256
) (
   // Clock
   input wire logic sys_clk,
   // Write side
   input wire logic wr_en,
   input wire logic [$clog2(DEPTH)-1:0] wr_addr,
   input wire logic [WIDTH-1:0] wr_data,
   // Read side
   input wire logic [$clog2(DEPTH)-1:0] rd_addr,
   output logic [WIDTH-1:0] rd_data
);

   logic [WIDTH-1:0] mem [DEPTH];

   // Write on the edge, read data from a register
   always_ff @(posedge sys_clk) begin
      if (wr_en) begin
         mem[wr_addr] <= wr_data;
      end
      rd_data <= mem[rd_addr];
   end

endmodule

`default_nettype wire

// file: testbench/prog_store_model.sv
// Program store model: writes a program image into the core's store.
// Assumes the core is held in master clear while the image is loaded.
`timescale 1ns/1ns
`default_nettype none

module prog_store_model (
   // Clock and request
   input wire logic sys_clk,
   input wire logic start,
   input wire logic [17:0][13:0] image,
   // Core load port
   output logic load_en,
   output logic [12:0] load_addr,
   output logic [13:0] load_word,
   output logic done
);
   int idx = 0;

   initial begin
      load_en = 1'b0;
      load_addr = 13'h0000;
      load_word = 14'h0000;
      done = 1'b0;
   end

   // One whole word per write, addresses inside the smallest store
   always @(posedge sys_clk) begin
      if (!start || done) begin
         load_en <= 1'b0;
         load_word <= ~load_word; // Idle data is not held
      end else if (idx == 18) begin
         load_en <= 1'b0;
         done <= 1'b1;
      end else begin
         load_en <= 1'b1;
         load_addr <= 13'(idx);
         load_word <= image[idx];
         idx <= idx + 1;
      end
   end
endmodule
`default_nettype wire

// file: testbench/testbench.sv
// Self-checking bench for the core datapath.
// Assumes the program is loaded while master clear holds the core.
`timescale 1ns/1ns
`default_nettype none

module testbench;
   import risc_core_pkg::*;
   typedef struct packed {logic [13:0] word; logic [7:0] w; logic [2:0] f;}
      row_type;
   logic sys_clk, resetn, master_clear_n, rc_mode, start, done, load_en;
   logic instr_rate_out;
   logic [12:0] load_addr, prog_counter;
   logic [13:0] load_word;
   logic [17:0][13:0] image;
   logic [7:0] work_reg, status_reg;
   logic [7:0] s;
   int n_fail = 0, compares = 0, cycles = 0, k;
   // Word, expected W, expected {zero, nibble carry, carry}
   row_type rows [14] = '{
      '{14'h300F, 8'h0F, 3'h0}, '{14'h3E01, 8'h10, 3'h2},
      '{14'h3EF0, 8'h00, 3'h5}, '{14'h3005, 8'h05, 3'h5},
      '{14'h3C03, 8'hFE, 3'h0}, '{14'h3CFE, 8'h00, 3'h7},
      '{14'h30A5, 8'hA5, 3'h7}, '{14'h380F, 8'hAF, 3'h3},
      '{14'h3950, 8'h00, 3'h7}, '{14'h3A3C, 8'h3C, 3'h3},
      '{14'h00A0, 8'h3C, 3'h3}, '{14'h0720, 8'h78, 3'h2},
      '{14'h02A0, 8'h78, 3'h2}, '{14'h0820, 8'hC4, 3'h2}};

   risc_core_alu_datapath #(.PROG_WORDS(512)) risc_core_alu_datapath_inst (
      .sys_clk(sys_clk), .resetn(resetn), .master_clear_n(master_clear_n),
      .rc_mode(rc_mode), .instr_rate_out(instr_rate_out),
      .load_en(load_en), .load_addr(load_addr), .load_word(load_word),
      .work_reg(work_reg), .status_reg(status_reg),
      .prog_counter(prog_counter));

   prog_store_model prog_store_model_inst (
      .sys_clk(sys_clk), .start(start), .image(image), .load_en(load_en),
      .load_addr(load_addr), .load_word(load_word), .done(done));

   // ---------------------------------------------
   // Clock, timeout and reporting
   // ---------------------------------------------
   initial begin
      sys_clk = 1'b0;
      forever #50 sys_clk = ~sys_clk;
   end

   always @(posedge sys_clk) begin
      cycles <= cycles + 1;
      if (cycles == 3000) begin
         n_fail = n_fail + 1;
         stop_test();
      end
   end

   task automatic check(input logic [15:0] seen, input logic [15:0] exp);
      compares = compares + 1;
      if (seen !== exp) begin
         n_fail = n_fail + 1;
         $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask

   task automatic stop_test();
      $display("compares %0d n_fail %0d", compares, n_fail);
      if (n_fail == 0 && compares > 0)
         $display("Run complete: PASS");
      else
         $display("Run complete: FAIL");
      $finish;
   endtask

   task automatic check_reset();
      check(16'(prog_counter), 16'h0000);
      check(16'(work_reg), 16'h0000);
      check(16'(status_reg), 16'(STATUS_RESET));
   endtask

   // ---------------------------------------------
   // Main sequence
   // ---------------------------------------------
   initial begin
      resetn = 1'b0;
      master_clear_n = 1'b0;
      rc_mode = 1'b1;
      start = 1'b0;
      foreach (rows[i]) image[i] = rows[i].word;
      // Branch test: jump over the load of 77h to the load of 42h, then loop in place
      image[14] = 14'h2810;
      image[15] = 14'h3077;
      image[16] = 14'h3042;
      image[17] = 14'h2811;
      repeat (4) @(posedge sys_clk);
      resetn <= 1'b1;
      start <= 1'b1;
      k = 0;
      while (done !== 1'b1 && k < 40) begin
         @(posedge sys_clk);
         k++;
      end
      #1 check_reset();
      @(posedge sys_clk);
      master_clear_n <= 1'b1;
      // Row loop: one instruction each four clocks
      k = 0;
      while (prog_counter !== 13'h0002 && k < 40) begin
         @(posedge sys_clk);
         #1 k++;
      end
      foreach (rows[i]) begin
         if (i > 0) @(posedge sys_clk);
         #1 check(16'(prog_counter), 16'(i + 2));
         repeat (3) @(posedge sys_clk);
         #1 check(16'(work_reg), 16'(rows[i].w));
         check(16'(status_reg[2:0]), 16'(rows[i].f));
      end
      // Branch flushes the fetched word and costs one extra cycle
      k = 0;
      while (work_reg !== 8'h42 && k < 30) begin
         @(posedge sys_clk);
         #1 k++;
         if (work_reg === 8'h77) check(16'(work_reg), 16'h0042);
      end
      check(16'(k), 16'h000C);
      // Rate output: period of four clocks, half high
      for (int i = 0; i < 8; i++) begin
         @(posedge sys_clk);
         #1 s[i] = instr_rate_out;
      end
      check(16'(s[3:0]), 16'(s[7:4]));
      check(16'($countones(s[3:0])), 16'h0002);
      check(16'(s[0] ^ s[2]), 16'h0001);
      @(posedge sys_clk);
      rc_mode <= 1'b0;
      repeat (4) @(posedge sys_clk);
      for (int i = 0; i < 4; i++) begin
         @(posedge sys_clk);
         #1 check(16'(instr_rate_out), 16'h0000);
      end
      // Master clear in mid-run, then a clean restart from address 0
      @(posedge sys_clk);
      master_clear_n <= 1'b0;
      repeat (5) @(posedge sys_clk);
      #1 check_reset();
      @(posedge sys_clk);
      master_clear_n <= 1'b1;
      k = 0;
      while (prog_counter !== 13'h0002 && k < 40) begin
         @(posedge sys_clk);
         #1 k++;
      end
      repeat (3) @(posedge sys_clk);
      #1 check(16'(work_reg), 16'(rows[0].w));
      check(16'(status_reg), 16'(STATUS_RESET));
      stop_test();
   end
endmodule
`default_nettype wire
